// ### ddrp_pkg.sv
// ddrp_pkg: constants, types and command coding for the DDR pin interface
// assumes a single 100 MHz core clock drives every module that imports it
package ddrp_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int          CLK_NS    = 10;       // core clock period
    localparam int          INIT_NS   = 200000;   // power-up hold of clock enable
    localparam int          CNT_W     = 15;
    localparam logic [1:0]  PH_LAST   = 2'h3;     // phase before command clock rise
    localparam logic [1:0]  PH_RST    = 2'h0;
    localparam int          LANES     = 8;

    // write burst steps, counted from the cycle of the command edge
    localparam logic [14:0] WR_DQS_ON = 15'h0001;
    localparam logic [14:0] WR_DQ_ON  = 15'h0003;
    localparam logic [14:0] WR_HIGH   = 15'h0004;
    localparam logic [14:0] WR_B1     = 15'h0005;
    localparam logic [14:0] WR_LAST   = 15'h0006;

    // read window
    localparam logic [14:0] RD_TMO    = 15'h003F;
    localparam int          RX_LEAD   = 3;
    localparam int          RX_TAIL   = 8;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [3:0]  CS_IDLE   = 4'hF;
    localparam logic [3:0]  CKE_RST   = 4'h0;
    localparam logic [3:0]  CKE_ALL   = 4'hF;
    localparam logic [2:0]  CODE_NOP  = 3'h7;

    // ----------------------------------------------------------------
    // commands and states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_ACT = 3'h1,
        OP_RD  = 3'h2,
        OP_WR  = 3'h3,
        OP_PRE = 3'h4,
        OP_REF = 3'h5,
        OP_MRS = 3'h6
    } ddrp_op_t;

    typedef enum logic [4:0] {
        ST_INIT = 5'h01,
        ST_IDLE = 5'h02,
        ST_WR   = 5'h04,
        ST_RD   = 5'h08,
        ST_SREF = 5'h10
    } ddrp_state_t;

    // {row strobe, column strobe, write enable}, all active low
    function automatic logic [2:0] ddrp_code(input ddrp_op_t op);
        unique case (op)
            OP_ACT:  ddrp_code = 3'h3;
            OP_RD:   ddrp_code = 3'h5;
            OP_WR:   ddrp_code = 3'h4;
            OP_PRE:  ddrp_code = 3'h2;
            OP_REF:  ddrp_code = 3'h1;
            OP_MRS:  ddrp_code = 3'h0;
            default: ddrp_code = CODE_NOP;
        endcase
    endfunction : ddrp_code

endpackage : ddrp_pkg

// ### ddrp_lane_if.sv
// ddrp_lane_if: write controls and read returns between the sequencer and byte lanes
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface ddrp_lane_if;
    logic         wr_oe;
    logic         dqs_oe;
    logic         dqs_lvl;
    logic         beat1;
    logic [127:0] wr_data;
    logic [15:0]  wr_mask;
    logic         rx_gate;
    wire  [127:0] rd_data;
    wire  [7:0]   rd_done;

    modport ctl  (output wr_oe, dqs_oe, dqs_lvl, beat1, wr_data, wr_mask, rx_gate,
                  input  rd_data, rd_done);
    modport lane (input  wr_oe, dqs_oe, dqs_lvl, beat1, wr_data, wr_mask, rx_gate,
                  output rd_data, rd_done);
endinterface : ddrp_lane_if

// ### ddrp_lane.sv
// ddrp_lane: one byte lane of data, mask and strobe pins
// assumes pins arrive asynchronously and controls come from the sequencer
`timescale 1ns/1ps
module ddrp_lane
    import ddrp_pkg::*;
#(
    parameter int IDX = 0
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // sequencer side
    ddrp_lane_if.lane       lif,
    // pins
    input  wire logic [7:0] dq_in,
    output logic [7:0]      dq_out,
    output logic [7:0]      dq_oe,
    input  wire logic       dqs_in,
    output logic            dqs_out,
    output logic            dqs_oe,
    output logic            dm_out
);
    import ddrp_pkg::*;

    typedef struct packed {
        logic [7:0] dq_s1;
        logic [7:0] dq_s2;
        logic       dqs_s1;
        logic       dqs_s2;
        logic       dqs_s3;
        logic       edge_d;
        logic       rise_d;
        logic [7:0] b0;
        logic [7:0] b1;
        logic       done;
        logic [7:0] dq_o;
        logic       dq_e;
        logic       dqs_o;
        logic       dqs_e;
        logic       dm_o;
    } ddrp_lane_st_t;

    ddrp_lane_st_t s_reg;
    ddrp_lane_st_t s_next;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next        = s_reg;
        s_next.dq_s1  = dq_in;
        s_next.dq_s2  = s_reg.dq_s1;
        s_next.dqs_s1 = dqs_in;
        s_next.dqs_s2 = s_reg.dqs_s1;
        s_next.dqs_s3 = s_reg.dqs_s2;
        // strobes come back edge aligned; sampling one cycle after the edge
        // lands mid-eye since each beat lasts two core cycles
        s_next.edge_d = (s_reg.dqs_s2 ^ s_reg.dqs_s3) & lif.rx_gate;
        s_next.rise_d = s_reg.dqs_s2;
        s_next.done   = 1'b0;
        if (s_reg.edge_d) begin
            if (s_reg.rise_d) begin
                s_next.b0 = s_reg.dq_s2;
            end else begin
                s_next.b1   = s_reg.dq_s2;
                s_next.done = 1'b1;
            end
        end
        s_next.dq_o  = lif.beat1 ? lif.wr_data[64+IDX*8 +: 8] : lif.wr_data[IDX*8 +: 8];
        s_next.dq_e  = lif.wr_oe;
        s_next.dqs_o = lif.dqs_lvl;
        s_next.dqs_e = lif.dqs_oe;
        s_next.dm_o  = lif.wr_oe & (lif.beat1 ? lif.wr_mask[8+IDX] : lif.wr_mask[IDX]);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dq_out  = s_reg.dq_o;
    assign dq_oe   = {8{s_reg.dq_e}};
    assign dqs_out = s_reg.dqs_o;
    assign dqs_oe  = s_reg.dqs_e;
    assign dm_out  = s_reg.dm_o;
    assign lif.rd_data[IDX*8 +: 8]    = s_reg.b0;
    assign lif.rd_data[64+IDX*8 +: 8] = s_reg.b1;
    assign lif.rd_done[IDX]           = s_reg.done;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_dqs_center;
        $rose(dqs_out) |-> $past(dq_oe[0]) && $stable(dq_out);
    endproperty
    a_dqs_center: assert property (p_dqs_center) else $error("strobe rose with data edge");

    property p_mask_wr;
        !dq_oe[0] |-> !dm_out;
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask outside write");

    property p_oe_pair;
        dq_oe[0] |-> dqs_oe;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("data driven without strobe");

    property p_cap_gate;
        lif.rd_done[IDX] |-> $past(lif.rx_gate, 2);
    endproperty
    a_cap_gate: assert property (p_cap_gate) else $error("capture outside window");

    property p_byte_map;
        lif.rd_done[IDX] |-> lif.rd_data[64+IDX*8 +: 8] == $past(s_reg.dq_s2);
    endproperty
    a_byte_map: assert property (p_byte_map) else $error("wrong byte captured");

endmodule : ddrp_lane

// ### ddrp_pin_ctrl.sv
// ddrp_pin_ctrl: command, clock, clock-enable and data pin sequencing for DDR memory
// assumes memory pins are asynchronous to sys_clk and user ports are on sys_clk
`timescale 1ns/1ps

// How it works
// - each command clock is a true/complement pair
// - six command clock pairs, three per module
// - four active-low row selects, change on rise
// - thirteen-bit multiplexed row/column address
// - duplicate copy of address bits 5,4,2,1
// - two-bit bank address selects internal bank
// - strobes plus row select encode each command
// - 64-bit bidirectional data bus
// - per-byte write mask, valid both strobe edges
// - write strobe centered; read strobe edge aligned
// - strobe n times data byte n
// - clock enable for init and self-refresh
// - per-row clock enable powers down idle rows
// - receive-enable loop gates read strobe capture
module ddrp_pin_ctrl
    import ddrp_pkg::*;
#(
    parameter int INIT_CYC = ddrp_pkg::INIT_NS / ddrp_pkg::CLK_NS,
    parameter int CAS_LAT  = 2
) (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    // command port
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    input  wire ddrp_pkg::ddrp_op_t   cmd_op,
    input  wire logic [1:0]           cmd_row,
    input  wire logic [1:0]           cmd_bank,
    input  wire logic [12:0]          cmd_addr,
    input  wire logic [127:0]         cmd_wdata,
    input  wire logic [15:0]          cmd_wmask,
    // power control
    input  wire logic [3:0]           idle_rows,
    input  wire logic                 suspend_req,
    output logic                      init_done,
    // read return
    output logic                      rd_valid,
    output logic [127:0]              rd_data,
    output logic                      rd_timeout,
    // memory command pins
    output logic [5:0]                mem_cmd_clock_pair_p,
    output logic [5:0]                mem_cmd_clock_pair_n,
    output logic [3:0]                mem_row_select_n,
    output logic [12:0]               mem_addr_primary,
    output logic [3:0]                mem_addr_duplicate,
    output logic [1:0]                mem_bank_addr,
    output logic                      mem_row_strobe_n,
    output logic                      mem_col_strobe_n,
    output logic                      mem_write_en_n,
    output logic [3:0]                mem_row_clk_enable,
    // memory data pins
    input  wire logic [63:0]          mem_data_lines_in,
    output logic [63:0]               mem_data_lines_out,
    output logic [63:0]               mem_data_lines_oe,
    output logic [7:0]                mem_byte_mask,
    input  wire logic [7:0]           mem_data_strobe_in,
    output logic [7:0]                mem_data_strobe_out,
    output logic [7:0]                mem_data_strobe_oe,
    // receive-enable loop
    output logic                      rx_enable_feedback_out_n,
    input  wire logic                 rx_enable_feedback_in_n
);
    import ddrp_pkg::*;

    localparam int          RX_ON  = 4 * CAS_LAT - RX_LEAD;
    localparam int          RX_OFF = 4 * CAS_LAT + RX_TAIL;
    localparam int          RX_A   = RX_ON + 2;
    localparam logic [14:0] INIT_LAST = CNT_W'(INIT_CYC - 1);

    typedef struct packed {
        ddrp_state_t  st;
        logic [1:0]   ph;
        logic         ck;
        logic         ckn;
        logic [3:0]   cs_n;
        logic [12:0]  addr;
        logic [3:0]   dup;
        logic [1:0]   ba;
        logic [2:0]   code;
        logic [3:0]   cke;
        logic [14:0]  cnt;
        logic [127:0] wdata;
        logic [15:0]  wmask;
        logic         rx_out_n;
        logic         rxi_s1;
        logic         rxi_s2;
        logic [7:0]   dmask;
        logic [127:0] rdata;
        logic         rvalid;
        logic         rtmo;
    } ddrp_main_st_t;

    ddrp_main_st_t s_reg;
    ddrp_main_st_t s_next;
    ddrp_lane_if   lif ();

    logic rising;
    logic take;
    logic [3:0] row_hot;

    assign rising    = (s_reg.ph == PH_LAST);
    assign cmd_ready = (s_reg.st == ST_IDLE) & rising & ~suspend_req;
    assign take      = cmd_valid & cmd_ready;
    assign row_hot   = 4'h1 << cmd_row;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        s_next        = s_reg;
        s_next.ph     = s_reg.ph + 2'h1;
        s_next.ck     = ~s_next.ph[1];
        s_next.ckn    = s_next.ph[1];
        s_next.cnt    = s_reg.cnt + 15'h0001;
        s_next.rxi_s1 = rx_enable_feedback_in_n;
        s_next.rxi_s2 = s_reg.rxi_s1;
        s_next.dmask  = s_reg.dmask | lif.rd_done;
        s_next.rvalid = 1'b0;
        s_next.rtmo   = 1'b0;
        // one command per clock: pins fall back to deselect at each rise
        if (rising) begin
            s_next.cs_n = CS_IDLE;
            s_next.code = CODE_NOP;
        end
        unique case (s_reg.st)
            ST_INIT: begin
                s_next.cke = CKE_RST;
                if (rising && s_reg.cnt >= INIT_LAST) begin
                    s_next.cke = CKE_ALL;
                    s_next.st  = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (rising) begin
                    // a row being addressed is woken even if marked idle
                    s_next.cke = ~idle_rows | (take ? row_hot : 4'h0);
                    if (take) begin
                        s_next.cs_n = ~row_hot;
                        s_next.code = ddrp_code(cmd_op);
                        s_next.addr = cmd_addr;
                        s_next.dup  = {cmd_addr[5], cmd_addr[4], cmd_addr[2], cmd_addr[1]};
                        s_next.ba   = cmd_bank;
                        s_next.cnt  = '0;
                        if (cmd_op == OP_WR) begin
                            s_next.st    = ST_WR;
                            s_next.wdata = cmd_wdata;
                            s_next.wmask = cmd_wmask;
                        end else if (cmd_op == OP_RD) begin
                            s_next.st    = ST_RD;
                            s_next.dmask = 8'h00;
                        end
                    end else if (suspend_req) begin
                        // self-refresh entry: refresh to all rows with enable low
                        s_next.cs_n = ~CS_IDLE;
                        s_next.code = ddrp_code(OP_REF);
                        s_next.cke  = CKE_RST;
                        s_next.st   = ST_SREF;
                    end
                end
            end
            ST_WR: begin
                if (s_reg.cnt == WR_LAST) begin
                    s_next.st = ST_IDLE;
                end
            end
            ST_RD: begin
                s_next.rx_out_n = !(s_reg.cnt >= CNT_W'(RX_ON)
                                    && s_reg.cnt <= CNT_W'(RX_OFF));
                if (&s_next.dmask) begin
                    s_next.rvalid   = 1'b1;
                    s_next.rdata    = lif.rd_data;
                    s_next.rx_out_n = 1'b1;
                    s_next.st       = ST_IDLE;
                end else if (s_reg.cnt == RD_TMO) begin
                    s_next.rtmo     = 1'b1;
                    s_next.rx_out_n = 1'b1;
                    s_next.st       = ST_IDLE;
                end
            end
            ST_SREF: begin
                // memory needs its exit delay; the user waits before commands
                if (rising && !suspend_req) begin
                    s_next.cke = CKE_ALL;
                    s_next.st  = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_reg          <= '0;
            s_reg.st       <= ST_INIT;
            s_reg.ph       <= PH_RST;
            s_reg.ck       <= 1'b1;
            s_reg.cs_n     <= CS_IDLE;
            s_reg.code     <= CODE_NOP;
            s_reg.cke      <= CKE_RST;
            s_reg.rx_out_n <= 1'b1;
            s_reg.rxi_s1   <= 1'b1;
            s_reg.rxi_s2   <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // lane controls and pins
    // ----------------------------------------------------------------
    assign lif.wr_oe   = (s_reg.st == ST_WR) && s_reg.cnt >= WR_DQ_ON;
    assign lif.dqs_oe  = (s_reg.st == ST_WR) && s_reg.cnt >= WR_DQS_ON;
    assign lif.dqs_lvl = (s_reg.st == ST_WR) && (s_reg.cnt == WR_HIGH
                                             || s_reg.cnt == WR_HIGH + 15'h0001);
    assign lif.beat1   = s_reg.cnt >= WR_B1;
    assign lif.wr_data = s_reg.wdata;
    assign lif.wr_mask = s_reg.wmask;
    assign lif.rx_gate = ~s_reg.rxi_s2;

    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            ddrp_lane #(.IDX(gi)) u_lane (
                .sys_clk (sys_clk),
                .resetn  (resetn),
                .lif     (lif),
                .dq_in   (mem_data_lines_in[gi*8 +: 8]),
                .dq_out  (mem_data_lines_out[gi*8 +: 8]),
                .dq_oe   (mem_data_lines_oe[gi*8 +: 8]),
                .dqs_in  (mem_data_strobe_in[gi]),
                .dqs_out (mem_data_strobe_out[gi]),
                .dqs_oe  (mem_data_strobe_oe[gi]),
                .dm_out  (mem_byte_mask[gi])
            );
        end
    endgenerate

    assign mem_cmd_clock_pair_p     = {6{s_reg.ck}};
    assign mem_cmd_clock_pair_n     = {6{s_reg.ckn}};
    assign mem_row_select_n         = s_reg.cs_n;
    assign mem_addr_primary         = s_reg.addr;
    assign mem_addr_duplicate       = s_reg.dup;
    assign mem_bank_addr            = s_reg.ba;
    assign mem_row_strobe_n         = s_reg.code[2];
    assign mem_col_strobe_n         = s_reg.code[1];
    assign mem_write_en_n           = s_reg.code[0];
    assign mem_row_clk_enable       = s_reg.cke;
    assign rx_enable_feedback_out_n = s_reg.rx_out_n;
    assign init_done                = (s_reg.st != ST_INIT);
    assign rd_valid                 = s_reg.rvalid;
    assign rd_data                  = s_reg.rdata;
    assign rd_timeout               = s_reg.rtmo;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_ck_pair;
        mem_cmd_clock_pair_p == ~mem_cmd_clock_pair_n;
    endproperty
    a_ck_pair: assert property (p_ck_pair) else $error("clock pair not complementary");

    property p_ck_six;
        $rose(mem_cmd_clock_pair_p[0]) |-> mem_cmd_clock_pair_p == 6'h3F ##2 mem_cmd_clock_pair_p == 6'h00;
    endproperty
    a_ck_six: assert property (p_ck_six) else $error("clock pairs out of step");

    property p_cs_rise;
        $changed(mem_row_select_n) |-> $rose(mem_cmd_clock_pair_p[0]);
    endproperty
    a_cs_rise: assert property (p_cs_rise) else $error("row select moved off rise");

    property p_addr_rise;
        $changed(mem_addr_primary) |-> $rose(mem_cmd_clock_pair_p[0]);
    endproperty
    a_addr_rise: assert property (p_addr_rise) else $error("address moved off rise");

    property p_dup;
        mem_addr_duplicate == {mem_addr_primary[5], mem_addr_primary[4],
                               mem_addr_primary[2], mem_addr_primary[1]};
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate address differs");

    property p_bank_rise;
        $changed(mem_bank_addr) |-> $rose(mem_cmd_clock_pair_p[0]);
    endproperty
    a_bank_rise: assert property (p_bank_rise) else $error("bank moved off rise");

    property p_cmd_sel;
        {mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n} != CODE_NOP
            |-> mem_row_select_n != CS_IDLE;
    endproperty
    a_cmd_sel: assert property (p_cmd_sel) else $error("command without row select");

    property p_wr_code;
        take && cmd_op == OP_WR |=> {mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n}
            == 3'h4 && !mem_row_select_n[$past(cmd_row)] [*4];
    endproperty
    a_wr_code: assert property (p_wr_code) else $error("write code wrong");

    sequence s_wr_take;
        take && cmd_op == OP_WR;
    endsequence
    sequence s_wr_strobe;
        lif.dqs_oe [*6] ##1 !lif.dqs_oe;
    endsequence
    property p_wr_burst;
        s_wr_take |-> ##2 s_wr_strobe;
    endproperty
    a_wr_burst: assert property (p_wr_burst) else $error("write strobe window wrong");

    property p_cke_hold;
        s_reg.st == ST_INIT || s_reg.st == ST_SREF |-> mem_row_clk_enable == CKE_RST;
    endproperty
    a_cke_hold: assert property (p_cke_hold) else $error("clock enable high in init or sleep");

    property p_cke_rise;
        $changed(mem_row_clk_enable) |-> $rose(mem_cmd_clock_pair_p[0]);
    endproperty
    a_cke_rise: assert property (p_cke_rise) else $error("clock enable moved off rise");

    property p_rx_open;
        take && cmd_op == OP_RD |-> ##RX_A !rx_enable_feedback_out_n;
    endproperty
    a_rx_open: assert property (p_rx_open) else $error("receive enable not opened");

endmodule : ddrp_pin_ctrl

// ### ddrp_mem_model.sv
// ddrp_mem_model: memory row model that answers reads with a two-beat burst
// assumes command pins stand four core cycles and the loop pin is wired back
`timescale 1ns/1ps
module ddrp_mem_model (
    // clock
    input  wire logic         sys_clk,
    // command pins
    input  wire logic         none_sel,
    input  wire logic [2:0]   code,
    // data pins
    input  wire logic [127:0] rdata,
    output logic [63:0]       dq,
    output logic [7:0]        dqs,
    // receive-enable loop
    input  wire logic         rxo_n,
    output logic              rxi_n
);
    // ------------------------------------------------------------
    // read burst
    // ------------------------------------------------------------
    int cnt = 0;
    assign rxi_n = rxo_n;
    initial begin
        dq  = 64'h0;
        dqs = 8'h00;
    end
    always @(posedge sys_clk) begin
        if (cnt == 0 && !none_sel && code == 3'h5)
            cnt <= 1;
        else if (cnt != 0)
            cnt <= cnt + 1;
        // strobe edges sit on the data changes, not in the eye
        if (cnt == 7) begin
            dqs <= 8'hFF;
            dq  <= rdata[63:0];
        end
        if (cnt == 9) begin
            dqs <= 8'h00;
            dq  <= rdata[127:64];
        end
        // released lines must not keep showing the last beat
        if (cnt == 11)
            dq <= ~dq;
        if (cnt > 11 && rxo_n) begin
            dqs <= ~dqs;
            cnt <= 0;
        end
    end
endmodule : ddrp_mem_model

// ### tb_top.sv
// tb_top: self-checking bench for ddrp_pin_ctrl against a memory row model
// assumes a shortened init count of 20 cycles
`timescale 1ns/1ps
module tb_top;
    import ddrp_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [127:0] RD_PAT = 128'h8899AABBCCDDEEFF_0011223344556677;
    localparam logic [127:0] WR_PAT = 128'hF0E1D2C3B4A59687_0F1E2D3C4B5A6978;
    logic         sys_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, suspend_req = 1'b0;
    ddrp_op_t     cmd_op = OP_NOP;
    logic [1:0]   cmd_row = 2'h0, cmd_bank = 2'h0, ba;
    logic [12:0]  cmd_addr = 13'h0000, ad;
    logic [3:0]   idle_rows = 4'h0, cs_n, cke, adup;
    logic         cmd_ready, init_done, rd_valid, rd_timeout, ras_n, cas_n, we_n, rxo_n, rxi_n;
    logic [127:0] rd_data;
    logic [5:0]   ck_p, ck_n;
    logic [63:0]  dqo, dqoe, m_dq;
    logic [7:0]   dm, dso, dsoe, m_dqs;
    int           num_errors = 0, num_checks = 0;
    always #5 sys_clk = ~sys_clk;
    ddrp_pin_ctrl #(.INIT_CYC(20), .CAS_LAT(2)) i_dut (
        .sys_clk, .resetn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_row, .cmd_bank, .cmd_addr,
        .cmd_wdata(WR_PAT), .cmd_wmask(16'h8001), .idle_rows, .suspend_req, .init_done,
        .rd_valid, .rd_data, .rd_timeout, .mem_cmd_clock_pair_p(ck_p),
        .mem_cmd_clock_pair_n(ck_n), .mem_row_select_n(cs_n), .mem_addr_primary(ad),
        .mem_addr_duplicate(adup), .mem_bank_addr(ba), .mem_row_strobe_n(ras_n),
        .mem_col_strobe_n(cas_n), .mem_write_en_n(we_n), .mem_row_clk_enable(cke),
        .mem_data_lines_in((dqoe & dqo) | (~dqoe & m_dq)), .mem_data_lines_out(dqo),
        .mem_data_lines_oe(dqoe), .mem_byte_mask(dm),
        .mem_data_strobe_in((dsoe & dso) | (~dsoe & m_dqs)), .mem_data_strobe_out(dso),
        .mem_data_strobe_oe(dsoe), .rx_enable_feedback_out_n(rxo_n),
        .rx_enable_feedback_in_n(rxi_n));
    ddrp_mem_model i_mem (.sys_clk, .none_sel(&cs_n), .code({ras_n, cas_n, we_n}),
        .rdata(RD_PAT), .dq(m_dq), .dqs(m_dqs), .rxo_n, .rxi_n);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task automatic wait_hi(input int w);
        int n;
        n = 0;
        while (n < 400 && (w == 0 ? cmd_ready : w == 1 ? init_done : rd_valid) !== 1'b1) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 400) begin
            chk(1, 0);
            results();
        end
    endtask : wait_hi
    task automatic issue(input ddrp_op_t op, input logic [1:0] row);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_row = row;
        wait_hi(0);
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        @(negedge sys_clk);
    endtask : issue
    always @(negedge sys_clk) if (resetn) chk(ck_p, 6'(~ck_n));
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_cmds;
        logic [2:0] codes [4] = '{3'h3, 3'h2, 3'h1, 3'h0};
        ddrp_op_t   ops [4] = '{OP_ACT, OP_PRE, OP_REF, OP_MRS};
        for (int i = 0; i < 4; i++) begin
            cmd_addr = 13'h1A5A ^ 13'(i * 13'h0333);
            cmd_bank = 2'(i);
            issue(ops[i], 2'(i));
            chk({ras_n, cas_n, we_n}, codes[i]);
            chk(cs_n, 4'(~(4'h1 << i)));
            chk({ba, ad}, {cmd_bank, cmd_addr});
            chk(adup, {cmd_addr[5], cmd_addr[4], cmd_addr[2], cmd_addr[1]});
        end
    endtask : t_cmds
    task automatic t_write;
        issue(OP_WR, 2'h1);
        chk({ras_n, cas_n, we_n}, 3'h4);
        repeat (4) @(negedge sys_clk);
        chk(dqoe, 64'hFFFF_FFFF_FFFF_FFFF);
        chk({dsoe, dso, dqo, dm}, {16'hFFFF, WR_PAT[63:0], 8'h01});
        repeat (2) @(negedge sys_clk);
        chk({dso, dqo, dm}, {8'h00, WR_PAT[127:64], 8'h80});
    endtask : t_write
    task automatic t_read;
        issue(OP_RD, 2'h0);
        chk({ras_n, cas_n, we_n}, 3'h5);
        wait_hi(2);
        chk(rd_data, RD_PAT);
        chk(rd_timeout, 1'b0);
    endtask : t_read
    task automatic t_power(input logic [3:0] idle, input logic susp, input logic [3:0] exp);
        idle_rows = idle;
        suspend_req = susp;
        repeat (12) @(negedge sys_clk);
        chk(cke, exp);
    endtask : t_power
    initial begin
        repeat (12) @(negedge sys_clk);
        chk({cs_n, cke, ras_n, cas_n, we_n, rxo_n, dsoe}, {4'hF, 4'h0, 4'hF, 8'h00});
        resetn = 1'b1;
        wait_hi(1);
        t_power(4'h0, 1'b0, 4'hF);
        t_cmds();
        t_write();
        t_read();
        t_power(4'h5, 1'b0, 4'hA);
        t_power(4'h0, 1'b1, 4'h0);
        chk(cmd_ready, 1'b0);
        t_power(4'h0, 1'b0, 4'hF);
        results();
    end
endmodule : tb_top
